// *** include/csia_pkg.sv ***
// package for the core status and indirect access block
// assumes a 32-bit apb slave, one core clock, data file indices 00h..1Fh
package csia_pkg;

  // ==========================================================
  // data file indices (apb byte address is four times these)
  localparam logic [4:0] IDX_WINDOW = 5'h00;
  localparam logic [4:0] IDX_FLAGS = 5'h03;
  localparam logic [4:0] IDX_POINTER = 5'h04;
  localparam logic [4:0] IDX_PORT = 5'h06;
  localparam logic [4:0] IDX_FIRST_RAM = 5'h08;

  // ==========================================================
  // extra apb byte offsets
  localparam logic [11:0] OFS_FILE_LAST = 12'h07C;
  localparam logic [11:0] OFS_CMD = 12'h080;
  localparam logic [11:0] OFS_ALU = 12'h084;
  localparam logic [11:0] OFS_RESULT = 12'h088;
  localparam logic [11:0] OFS_IP = 12'h08C;
  localparam logic [11:0] OFS_DIR = 12'h090;
  localparam logic [11:0] OFS_OPTION = 12'h094;
  localparam logic [11:0] OFS_WATCHDOG = 12'h098;

  // ==========================================================
  // flag bit positions and command bits
  localparam int BIT_PIN_WAKE = 7;
  localparam int BIT_TIMEOUT = 4;
  localparam int BIT_POWER_DOWN = 3;
  localparam int BIT_ZERO = 2;
  localparam int BIT_DIGIT_CARRY = 1;
  localparam int BIT_CARRY = 0;
  localparam int CMD_CLEAR_WATCHDOG = 0;
  localparam int CMD_SLEEP = 1;
  localparam int CMD_WATCHDOG_RESET = 2;
  localparam int CMD_WAKE_RESET = 3;
  localparam int CMD_EXT_RESET = 4;
  localparam int CMD_STEP = 5;
  localparam int OPT_PRESCALER_TO_WATCHDOG = 3;

  // ==========================================================
  // reset values and address masks
  localparam logic [7:0] FLAGS_POR = 8'h18;
  localparam logic [7:0] FLAGS_WRITABLE = 8'h87;
  localparam logic [2:0] POINTER_HIGH = 3'h7;
  localparam logic [3:0] DIR_RESET = 4'hF;
  localparam logic [7:0] OPTION_RESET = 8'hFF;
  localparam logic [9:0] RESET_VECTOR = 10'h000;
  localparam logic [9:0] IP_MASK_LARGE = 10'h3FF;
  localparam logic [9:0] IP_MASK_SMALL = 10'h1FF;
  localparam logic [9:0] IMPL_MASK_LARGE = 10'h1FF;
  localparam logic [9:0] IMPL_MASK_SMALL = 10'h0FF;

  typedef enum logic [2:0] {
    ALU_ADD = 3'b000, ALU_SUB = 3'b001, ALU_AND = 3'b010, ALU_OR = 3'b011,
    ALU_XOR = 3'b100, ALU_COM = 3'b101, ALU_RRF = 3'b110, ALU_RLF = 3'b111
  } csia_alu_op_e;

  typedef struct packed {
    logic [7:0] result;
    logic zero;
    logic digit_carry;
    logic carry;
    logic upd_zero;
    logic upd_digit_carry;
    logic upd_carry;
  } csia_alu_res_s;

endpackage : csia_pkg

// *** rtl/csia_ram.sv ***
// general purpose data file memory
// assumes one clock; read data is registered, one cycle after the address
`timescale 1ns/1ns
`default_nettype none
module csia_ram #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);
  // ==========================================================
  // storage; contents are unknown after power-up, like the real file
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : csia_ram
`default_nettype wire

// *** rtl/csia_alu.sv ***
// arithmetic and logic unit with flag results
// assumes combinational use; the caller registers result and flags
`timescale 1ns/1ns
`default_nettype none
module csia_alu
  import csia_pkg::*;
(
  input wire csia_alu_op_e op,
  input wire logic [7:0] acc,
  input wire logic [7:0] file_val,
  input wire logic carry_in,
  output csia_alu_res_s res
);
  // ==========================================================
  // operation table
  logic [8:0] wide;
  logic [4:0] nib;
  always_comb begin
    wide = 9'h000;
    nib = 5'h00;
    res = '0;
    case (op)
      ALU_ADD: begin
        wide = {1'b0, file_val} + {1'b0, acc};
        nib = {1'b0, file_val[3:0]} + {1'b0, acc[3:0]};
        res.result = wide[7:0];
        res.carry = wide[8];
        res.digit_carry = nib[4];
        {res.upd_zero, res.upd_digit_carry, res.upd_carry} = 3'b111;
      end
      ALU_SUB: begin
        // carry and digit carry are inverted borrows: one means nothing was borrowed
        wide = {1'b0, file_val} - {1'b0, acc};
        res.result = wide[7:0];
        res.carry = (file_val >= acc);
        res.digit_carry = (file_val[3:0] >= acc[3:0]);
        {res.upd_zero, res.upd_digit_carry, res.upd_carry} = 3'b111;
      end
      ALU_AND: begin
        res.result = file_val & acc;
        res.upd_zero = 1'b1;
      end
      ALU_OR: begin
        res.result = file_val | acc;
        res.upd_zero = 1'b1;
      end
      ALU_XOR: begin
        res.result = file_val ^ acc;
        res.upd_zero = 1'b1;
      end
      ALU_COM: begin
        res.result = ~file_val;
        res.upd_zero = 1'b1;
      end
      ALU_RRF: begin
        res.result = {carry_in, file_val[7:1]};
        res.carry = file_val[0];
        res.upd_carry = 1'b1;
      end
      ALU_RLF: begin
        res.result = {file_val[6:0], carry_in};
        res.carry = file_val[7];
        res.upd_carry = 1'b1;
      end
      default: begin
        res = '0;
      end
    endcase
    res.zero = (res.result == 8'h00);
  end
endmodule : csia_alu
`default_nettype wire

// *** rtl/csia_core.sv ***
// core status flags, instruction pointer and indirect data access
// assumes an apb master on clk, port pins asynchronous to clk
//
// Summary of operation
// - large variant: 10-bit instruction pointer, only words 000h..1FFh exist.
// - large variant: fetch addresses above 1FFh wrap into the first 512 words.
// - small variant: 9-bit pointer, words 000h..0FFh exist, higher ones wrap.
// - every reset loads the instruction pointer with zero.
// - flags register at file 03h; bit 7 wake, 6:5 reserved, 4:0 flags.
// - pin-change wake reset sets bit 7; every other reset clears it.
// - sleep clears power-down flag; power-up and clear watchdog set it.
// - zero flag follows whether the result is zero, except on rotates, which leave it.
// - digit carry on low-nibble carry; on subtract it is an inverted borrow.
// - window accesses go to the file register the pointer selects.
// - window reading itself through a zero pointer returns zero.
// - window writing itself changes no register; the flags do not update either.
// - pointer has five bits selecting file addresses 00h..1Fh.
// - pointer bits 7:5 have no storage and read as ones.
// - unimplemented port bits read as zero.
// - clear watchdog resets counter, assigned prescaler, sets both flags.
`timescale 1ns/1ns
`default_nettype none
module csia_core
  import csia_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1,
  parameter int RAM_DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe,
  output logic [9:0] fetch_addr
);
  // ==========================================================
  // variant masks
  localparam logic [9:0] IP_MASK = LARGE_VARIANT ? IP_MASK_LARGE : IP_MASK_SMALL;
  localparam logic [9:0] IMPL_MASK = LARGE_VARIANT ? IMPL_MASK_LARGE : IMPL_MASK_SMALL;

  function automatic logic is_ram(input logic [4:0] idx);
    is_ram = (idx >= IDX_FIRST_RAM);
  endfunction : is_ram

  function automatic logic [9:0] wrap_ip(input logic [9:0] ip);
    wrap_ip = ip & IP_MASK;
  endfunction : wrap_ip

  // ==========================================================
  // state
  logic [7:0] core_status_flags_q;
  logic [4:0] indirect_pointer_q;
  logic [3:0] port_pin_data_q;
  logic [3:0] port_direction_q;
  logic [7:0] timer_wake_options_q;
  logic [9:0] instruction_pointer_q;
  logic [7:0] watchdog_counter_q;
  logic [7:0] prescaler_q;
  logic [7:0] alu_result_q;
  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [2:0] pin_out_q;
  logic [2:0] pin_oe_q;
  logic [9:0] fetch_addr_q;
  logic [7:0] ram_rdata;
  csia_alu_res_s alu_res;

  // ==========================================================
  // apb decode
  logic rd_phase;
  logic wr_acc;
  logic is_file;
  logic [4:0] file_idx;
  logic [4:0] eff_idx;
  logic self_ref;
  logic file_wr;
  logic cmd_acc;
  logic alu_acc;
  logic any_reset;

  assign rd_phase = psel && penable && !pready_q;
  assign wr_acc = psel && penable && pready_q && pwrite;
  assign is_file = (paddr <= OFS_FILE_LAST) && (paddr[1:0] == 2'b00);
  assign file_idx = paddr[6:2];
  // the window is not storage: every access is steered by the pointer
  assign eff_idx = (file_idx == IDX_WINDOW) ? indirect_pointer_q : file_idx;
  assign self_ref = (eff_idx == IDX_WINDOW);
  assign file_wr = wr_acc && is_file && !self_ref;
  assign cmd_acc = wr_acc && (paddr == OFS_CMD);
  assign alu_acc = wr_acc && (paddr == OFS_ALU);
  assign any_reset = cmd_acc && (pwdata[CMD_WATCHDOG_RESET] || pwdata[CMD_WAKE_RESET] ||
                                 pwdata[CMD_EXT_RESET]);

  // ==========================================================
  // apb handshake: one wait state on every transfer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= psel && penable && !pready_q;
    end
  end

  // ==========================================================
  // read data and error, captured as pready rises
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (rd_phase) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      if (is_file) begin
        if (self_ref) begin
          prdata_q <= 32'h0000_0000;
        end else if (eff_idx == IDX_FLAGS) begin
          prdata_q[7:0] <= core_status_flags_q;
        end else if (eff_idx == IDX_POINTER) begin
          prdata_q[7:0] <= {POINTER_HIGH, indirect_pointer_q};
        end else if (eff_idx == IDX_PORT) begin
          prdata_q[7:0] <= {4'h0, pin_sync_q};
        end else if (is_ram(eff_idx)) begin
          prdata_q[7:0] <= ram_rdata;
        end
      end else if (paddr == OFS_RESULT) begin
        prdata_q[7:0] <= alu_result_q;
      end else if (paddr == OFS_IP) begin
        prdata_q[9:0] <= instruction_pointer_q;
      end else if (paddr == OFS_WATCHDOG) begin
        prdata_q[7:0] <= watchdog_counter_q;
      end else if (paddr == OFS_CMD || paddr == OFS_ALU || paddr == OFS_DIR ||
                   paddr == OFS_OPTION) begin
        pslverr_q <= 1'b0; // write-only registers read as zero
      end else begin
        pslverr_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // general purpose file memory
  csia_ram #(
    .DEPTH(RAM_DEPTH),
    .WIDTH(8)
  ) u_ram (
    .clk(clk),
    .we(file_wr && is_ram(eff_idx)),
    .addr(eff_idx),
    .wdata(pwdata[7:0]),
    .rdata(ram_rdata)
  );

  // ==========================================================
  // alu, fed straight from the command word
  csia_alu u_alu (
    .op(csia_alu_op_e'(pwdata[18:16])),
    .acc(pwdata[15:8]),
    .file_val(pwdata[7:0]),
    .carry_in(core_status_flags_q[BIT_CARRY]),
    .res(alu_res)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alu_result_q <= 8'h00;
    end else if (alu_acc) begin
      alu_result_q <= alu_res.result;
    end
  end

  // ==========================================================
  // status flags; hardware events are applied last so they win
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_status_flags_q <= FLAGS_POR;
    end else begin
      if (file_wr && eff_idx == IDX_FLAGS) begin
        // timeout and power-down are read-only, reserved bits stay zero
        core_status_flags_q <= (pwdata[7:0] & FLAGS_WRITABLE) |
                               (core_status_flags_q & ~FLAGS_WRITABLE);
      end
      if (alu_acc) begin
        if (alu_res.upd_zero) begin
          core_status_flags_q[BIT_ZERO] <= alu_res.zero;
        end
        if (alu_res.upd_digit_carry) begin
          core_status_flags_q[BIT_DIGIT_CARRY] <= alu_res.digit_carry;
        end
        if (alu_res.upd_carry) begin
          core_status_flags_q[BIT_CARRY] <= alu_res.carry;
        end
      end
      if (cmd_acc) begin
        if (pwdata[CMD_CLEAR_WATCHDOG]) begin
          core_status_flags_q[BIT_TIMEOUT] <= 1'b1;
          core_status_flags_q[BIT_POWER_DOWN] <= 1'b1;
        end
        if (pwdata[CMD_SLEEP]) begin
          core_status_flags_q[BIT_TIMEOUT] <= 1'b1;
          core_status_flags_q[BIT_POWER_DOWN] <= 1'b0;
        end
        if (pwdata[CMD_WATCHDOG_RESET]) begin
          core_status_flags_q[BIT_TIMEOUT] <= 1'b0;
        end
        if (any_reset) begin
          core_status_flags_q[BIT_PIN_WAKE] <= pwdata[CMD_WAKE_RESET];
        end
      end
    end
  end

  // ==========================================================
  // indirect pointer, five stored bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      indirect_pointer_q <= 5'h00;
    end else if (file_wr && eff_idx == IDX_POINTER) begin
      indirect_pointer_q <= pwdata[4:0];
    end
  end

  // ==========================================================
  // port latch, direction and option
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_pin_data_q <= 4'h0;
      port_direction_q <= DIR_RESET;
      timer_wake_options_q <= OPTION_RESET;
    end else begin
      if (file_wr && eff_idx == IDX_PORT) begin
        port_pin_data_q <= pwdata[3:0];
      end
      if (wr_acc && paddr == OFS_DIR) begin
        port_direction_q <= pwdata[3:0];
      end
      if (wr_acc && paddr == OFS_OPTION) begin
        timer_wake_options_q <= pwdata[7:0];
      end
    end
  end

  // pins are asynchronous: two stages before anything reads them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= 4'h0;
      pin_sync_q <= 4'h0;
    end else begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // pin 3 is input only, so only three drivers exist
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out_q <= 3'h0;
      pin_oe_q <= 3'h0;
    end else begin
      pin_out_q <= port_pin_data_q[2:0];
      pin_oe_q <= ~port_direction_q[2:0];
    end
  end

  // ==========================================================
  // instruction pointer and fetch address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instruction_pointer_q <= RESET_VECTOR;
    end else if (any_reset) begin
      instruction_pointer_q <= RESET_VECTOR;
    end else if (cmd_acc && pwdata[CMD_STEP]) begin
      instruction_pointer_q <= wrap_ip(instruction_pointer_q + 10'h001);
    end else if (wr_acc && paddr == OFS_IP) begin
      instruction_pointer_q <= wrap_ip(pwdata[9:0]);
    end
  end

  // only the implemented words decode, so high addresses fold back down
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_addr_q <= RESET_VECTOR;
    end else begin
      fetch_addr_q <= instruction_pointer_q & IMPL_MASK;
    end
  end

  // ==========================================================
  // watchdog counter and prescaler, free running between clears
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_counter_q <= 8'h00;
      prescaler_q <= 8'h00;
    end else if (cmd_acc && (pwdata[CMD_CLEAR_WATCHDOG] || pwdata[CMD_SLEEP])) begin
      watchdog_counter_q <= 8'h00;
      if (timer_wake_options_q[OPT_PRESCALER_TO_WATCHDOG]) begin
        prescaler_q <= 8'h00;
      end else begin
        prescaler_q <= prescaler_q + 8'h01;
      end
    end else begin
      watchdog_counter_q <= watchdog_counter_q + 8'h01;
      prescaler_q <= prescaler_q + 8'h01;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;
  assign fetch_addr = fetch_addr_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_pointer_high_ones: assert property (
    rd_phase && !pwrite && is_file && eff_idx == IDX_POINTER |=> prdata_q[7:5] == 3'b111)
    else $error("pointer high bits not read as ones");
  chk_self_read_zero: assert property (
    rd_phase && !pwrite && is_file && self_ref |=> prdata_q == 32'h0000_0000)
    else $error("self-addressed window read not zero");
  chk_self_write_nop: assert property (
    wr_acc && is_file && self_ref |=> $stable(indirect_pointer_q) && $stable(port_pin_data_q))
    else $error("self-addressed window write changed a register");
  chk_reset_vector: assert property (
    any_reset |=> instruction_pointer_q == RESET_VECTOR ##1 fetch_addr_q == RESET_VECTOR)
    else $error("reset did not restart at zero");
  chk_wake_flag: assert property (
    any_reset |=> core_status_flags_q[BIT_PIN_WAKE] == $past(pwdata[CMD_WAKE_RESET]))
    else $error("wake flag does not match reset cause");
  chk_sleep_flags: assert property (
    cmd_acc && pwdata[CMD_SLEEP] && !pwdata[CMD_CLEAR_WATCHDOG] && !pwdata[CMD_WATCHDOG_RESET]
    |=> !core_status_flags_q[BIT_POWER_DOWN] && core_status_flags_q[BIT_TIMEOUT])
    else $error("sleep flags wrong");
  chk_clear_watchdog: assert property (
    cmd_acc && pwdata[CMD_CLEAR_WATCHDOG] && !pwdata[CMD_SLEEP] && !pwdata[CMD_WATCHDOG_RESET]
    |=> watchdog_counter_q == 8'h00 && core_status_flags_q[BIT_TIMEOUT] &&
        core_status_flags_q[BIT_POWER_DOWN] &&
        (prescaler_q == 8'h00 || !timer_wake_options_q[OPT_PRESCALER_TO_WATCHDOG]))
    else $error("clear watchdog effects missing");
  chk_timeout_clear: assert property (
    cmd_acc && pwdata[CMD_WATCHDOG_RESET] |=> !core_status_flags_q[BIT_TIMEOUT])
    else $error("watchdog time-out did not clear flag");
  chk_zero_flag: assert property (
    alu_acc && alu_res.upd_zero |=> core_status_flags_q[BIT_ZERO] == (alu_result_q == 8'h00))
    else $error("zero flag disagrees with result");
  chk_fetch_wrap: assert property (
    (fetch_addr_q & ~IMPL_MASK) == 10'h000)
    else $error("fetch address beyond implemented words");
  chk_reserved_zero: assert property (
    core_status_flags_q[6:5] == 2'b00)
    else $error("reserved flag bits set");
  chk_port_high_zero: assert property (
    rd_phase && !pwrite && is_file && eff_idx == IDX_PORT |=> prdata_q[7:4] == 4'h0)
    else $error("unimplemented port bits not zero");

  cov_indirect_ram_write: cover property (wr_acc && file_idx == IDX_WINDOW && is_ram(eff_idx));
  cov_wake_reset: cover property (cmd_acc && pwdata[CMD_WAKE_RESET]);
  cov_ip_wrap: cover property (cmd_acc && pwdata[CMD_STEP] && instruction_pointer_q == IP_MASK);
  cov_error: cover property (pslverr_q && pready_q);
endmodule : csia_core
`default_nettype wire

// *** dv/tb_top.sv ***
// testbench for the core status and indirect access block
// assumes csia_pkg compiled first; the bench drives apb and port pins itself
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import csia_pkg::*;
;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, prdata_s, rdat, rdat_s;
  logic [3:0] pin_in;
  logic [2:0] pin_out, pin_oe;
  logic [9:0] fetch_l, fetch_s;
  int mismatches = 0;
  int num_checks = 0;
  localparam logic [31:0] M8 = 32'h000000FF;

  // ==========================================================
  // clock and the two variants on one bus
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  csia_core #(.LARGE_VARIANT(1'b1), .RAM_DEPTH(32)) dut (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .fetch_addr(fetch_l));
  // small variant only answers the pointer checks; both see the same writes
  csia_core #(.LARGE_VARIANT(1'b0), .RAM_DEPTH(32)) dut_small (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata_s), .pready(), .pslverr(), .pin_in(pin_in),
    .pin_out(), .pin_oe(), .fetch_addr(fetch_s));

  // ==========================================================
  // access tasks
  function automatic logic [11:0] fa(input logic [4:0] i);
    return {5'h00, i, 2'b00};
  endfunction : fa
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk({31'h0, pready}, 32'h1);
    rdat = prdata;
    rdat_s = prdata_s;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdat & m, e);
  endtask : rc
  task automatic alu(input csia_alu_op_e op, input logic [7:0] acc, input logic [7:0] f,
                     input logic [31:0] rm, input logic [31:0] r, input logic [31:0] fl);
    wr(OFS_ALU, {13'h0000, op, acc, f});
    rc(OFS_RESULT, rm, r);
    rc(fa(IDX_FLAGS), 32'h7, fl);
  endtask : alu
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  // ==========================================================
  // watchdog: the whole run needs well under 2000 cycles
  initial begin
    #2000000;
    mismatches++;
    stop_test();
  end

  // ==========================================================
  // tests
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pin_in = 4'hA;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rc(fa(IDX_FLAGS), M8, 32'h18);
    rc(fa(IDX_POINTER), M8, 32'hE0);
    rc(OFS_IP, 32'h3FF, 32'h0);
    rc(OFS_DIR, 32'hFFFFFFFF, 32'h0);
    rc(fa(IDX_PORT), 32'hFFFFFFFF, 32'h0A);
    xfer(1'b0, 12'h0FC, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    wr(fa(IDX_FLAGS), 32'hFF);
    rc(fa(IDX_FLAGS), 32'hE0, 32'h80);
    $display("test reset_and_map done");
    wr(fa(5'h09), 32'h10);
    wr(fa(5'h0A), 32'h0A);
    wr(fa(IDX_POINTER), 32'h09);
    rc(fa(IDX_WINDOW), M8, 32'h10);
    wr(fa(IDX_POINTER), 32'h0A);
    rc(fa(IDX_WINDOW), M8, 32'h0A);
    wr(fa(IDX_POINTER), 32'hFF);
    rc(fa(IDX_POINTER), M8, 32'hFF);
    wr(fa(IDX_WINDOW), 32'h5A);
    rc(fa(5'h1F), M8, 32'h5A);
    wr(fa(IDX_POINTER), 32'h00);
    rc(fa(IDX_WINDOW), M8, 32'h00);
    wr(fa(IDX_WINDOW), 32'h77);
    rc(fa(IDX_POINTER), M8, 32'hE0);
    rc(fa(5'h09), M8, 32'h10);
    $display("test indirect done");
    alu(ALU_ADD, 8'h0F, 8'h01, M8, 32'h10, 32'h2);
    alu(ALU_ADD, 8'h80, 8'h80, M8, 32'h00, 32'h5);
    alu(ALU_SUB, 8'h03, 8'h05, M8, 32'h02, 32'h3);
    alu(ALU_SUB, 8'h05, 8'h03, M8, 32'hFE, 32'h0);
    alu(ALU_SUB, 8'h05, 8'h05, M8, 32'h00, 32'h7);
    alu(ALU_RRF, 8'h00, 8'h01, M8, 32'h80, 32'h7);
    alu(ALU_RLF, 8'h00, 8'h7F, M8, 32'hFF, 32'h6);
    alu(ALU_RLF, 8'h00, 8'h80, M8, 32'h00, 32'h7);
    alu(ALU_OR, 8'h30, 8'h03, M8, 32'h33, 32'h3);
    alu(ALU_AND, 8'hF0, 8'h0F, M8, 32'h00, 32'h7);
    alu(ALU_XOR, 8'h3C, 8'h0F, M8, 32'h33, 32'h3);
    alu(ALU_COM, 8'h00, 8'hFF, M8, 32'h00, 32'h7);
    $display("test alu_flags done");
    wr(OFS_CMD, 32'h1 << CMD_SLEEP);
    rc(fa(IDX_FLAGS), 32'h18, 32'h10);
    wr(OFS_CMD, 32'h1 << CMD_CLEAR_WATCHDOG);
    rc(fa(IDX_FLAGS), 32'h18, 32'h18);
    xfer(1'b0, OFS_WATCHDOG, 32'h0);
    chk({31'h0, rdat < 32'h10}, 32'h1);
    wr(OFS_CMD, 32'h1 << CMD_WATCHDOG_RESET);
    rc(fa(IDX_FLAGS), 32'h90, 32'h00);
    wr(OFS_CMD, 32'h1 << CMD_WAKE_RESET);
    rc(fa(IDX_FLAGS), 32'h80, 32'h80);
    $display("test commands done");
    // only the pointer moves; program words are never written
    wr(OFS_IP, 32'h3FF);
    rc(OFS_IP, 32'h3FF, 32'h3FF);
    chk({22'h0, fetch_l}, 32'h1FF);
    chk({22'h0, fetch_s}, 32'h0FF);
    chk(rdat_s, 32'h1FF);
    wr(OFS_CMD, 32'h1 << CMD_STEP);
    rc(OFS_IP, 32'h3FF, 32'h000);
    chk(rdat_s, 32'h000);
    wr(OFS_IP, 32'h1FF);
    wr(OFS_CMD, 32'h1 << CMD_STEP);
    rc(OFS_IP, 32'h3FF, 32'h200);
    chk({22'h0, fetch_l}, 32'h000);
    chk(rdat_s, 32'h000);
    wr(OFS_IP, 32'h155);
    wr(OFS_CMD, 32'h1 << CMD_EXT_RESET);
    rc(OFS_IP, 32'h3FF, 32'h000);
    chk({22'h0, fetch_l}, 32'h000);
    rc(fa(IDX_FLAGS), 32'h80, 32'h00);
    $display("test instruction_pointer done");
    wr(OFS_DIR, 32'h8);
    wr(fa(IDX_PORT), 32'hFD);
    repeat (2) @(posedge clk);
    chk({29'h0, pin_out}, 32'h5);
    chk({29'h0, pin_oe}, 32'h7);
    pin_in <= 4'h5;
    repeat (4) @(posedge clk);
    rc(fa(IDX_PORT), 32'hFFFFFFFF, 32'h05);
    $display("test port done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
